// [dsc_map.svh]
// register map, field positions and reset values of the downconverter sync control
// Functional notes
// - update mode 0: new words apply immediately
// - update mode 1: words wait for transfer
// - soft reset bit holds oscillators in reset
// - continuous mode resyncs on every rising sysref edge while path enabled and soft reset clear
// - one-shot mode uses only first sysref edge
// - one-shot capture clears sync enable bit
// - sync enable 0: no sysref alignment
// - mixer select: real or complex mixer
// - gain select doubles output, 6 dB
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// register indices, byte address is four times the index
`define DSC_IDX_XFER      12'h00f
`define DSC_IDX_SYNC      12'h300
`define DSC_IDX_DDC0      12'h310
`define DSC_IDX_FTW       12'h320
`define DSC_IDX_POW       12'h321
`define DSC_IDX_MAW       12'h322
`define DSC_IDX_MBW       12'h323
`define DSC_IDX_STAT      12'h324

// field positions
`define DSC_BIT_UPD_MODE  7
`define DSC_BIT_SOFT_RST  4
`define DSC_BIT_ONE_SHOT  1
`define DSC_BIT_SYNC_EN   0
`define DSC_BIT_MIXER     7
`define DSC_BIT_GAIN      6
`define DSC_BIT_XFER      0
`define DSC_BIT_PATH_EN   0
`define DSC_BIT_PENDING   1
`define DSC_BIT_STATE_LO  2

// writable bits and reset values
`define DSC_SYNC_WMASK    8'h93
`define DSC_DDC0_WMASK    8'hc0
`define DSC_STAT_WMASK    8'h01
`define DSC_RST_SYNC      8'h00
`define DSC_RST_DDC0      8'h00
`define DSC_RST_STAT      8'h00
`define DSC_RST_WORD      32'h0000_0000
`define DSC_NUM_WORDS     4

`endif

// [dsc_pkg.sv]
// types shared by the downconverter sync control
package dsc_pkg;
  typedef logic [31:0] dsc_word_t;
  typedef logic [7:0]  dsc_byte_t;
  typedef logic [13:0] dsc_addr_t;
  typedef logic [11:0] dsc_idx_t;
  typedef enum logic [1:0] {DSC_SY_OFF, DSC_SY_CONT, DSC_SY_ONCE} dsc_sync_state_t;
endpackage : dsc_pkg

// [dsc_sync2.sv]
// two-flop synchroniser for the sysref pin
`timescale 1ns/100ps
`default_nettype none
module dsc_sync2 (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // asynchronous level in, synchronous level out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : dsc_sync2
`default_nettype wire

// [dsc_sync_ctrl.sv]
// apb register bank and sysref alignment control of the downconverter oscillators
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dsc_map.svh"
module dsc_sync_ctrl (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // apb slave
  input  wire dsc_pkg::dsc_addr_t paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire dsc_pkg::dsc_word_t pwdata,
  input  wire logic [3:0]        pstrb,
  output dsc_pkg::dsc_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  // sysref pin
  input  wire logic              sysref_in,
  // oscillator control
  output dsc_pkg::dsc_word_t     frequency_tuning_word,
  output dsc_pkg::dsc_word_t     phase_offset_word,
  output dsc_pkg::dsc_word_t     modulus_a_word,
  output dsc_pkg::dsc_word_t     modulus_b_word,
  output logic                   oscillator_soft_reset,
  output logic                   nco_sync,
  output logic                   mixer_type_select,
  output logic                   six_db_gain_select
);
  import dsc_pkg::*;

  dsc_byte_t       sync_ctrl;
  dsc_byte_t       ddc0_ctrl;
  dsc_byte_t       stat_ctrl;
  logic            pending;
  dsc_sync_state_t sync_state;
  dsc_sync_state_t next_sync_state;
  dsc_word_t       shadow [`DSC_NUM_WORDS];
  dsc_word_t       active [`DSC_NUM_WORDS];
  wire dsc_word_t  merged [`DSC_NUM_WORDS];
  wire [`DSC_NUM_WORDS-1:0] word_wr;
  logic            sysref_s;
  logic            sysref_d;

  // bus decode
  wire dsc_idx_t  idx      = paddr[13:2];
  wire            aligned  = (paddr[1:0] == 2'h0);
  wire            access   = psel & penable;
  wire            wr_en    = access & pready & pwrite;
  wire            hit_xfer = aligned & (idx == `DSC_IDX_XFER);
  wire            hit_sync = aligned & (idx == `DSC_IDX_SYNC);
  wire            hit_ddc0 = aligned & (idx == `DSC_IDX_DDC0);
  wire            hit_stat = aligned & (idx == `DSC_IDX_STAT);
  wire            hit_ftw  = aligned & (idx == `DSC_IDX_FTW);
  wire            hit_pow  = aligned & (idx == `DSC_IDX_POW);
  wire            hit_maw  = aligned & (idx == `DSC_IDX_MAW);
  wire            hit_mbw  = aligned & (idx == `DSC_IDX_MBW);
  wire [`DSC_NUM_WORDS-1:0] hit_word = {hit_mbw, hit_maw, hit_pow, hit_ftw};
  wire            mapped   = hit_xfer | hit_sync | hit_ddc0 | hit_stat | (|hit_word);
  wire            sync_wr  = wr_en & hit_sync & pstrb[0];
  wire            ddc0_wr  = wr_en & hit_ddc0 & pstrb[0];
  wire            stat_wr  = wr_en & hit_stat & pstrb[0];
  wire dsc_word_t lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // control fields
  wire upd_mode = sync_ctrl[`DSC_BIT_UPD_MODE];
  wire soft_rst = sync_ctrl[`DSC_BIT_SOFT_RST];
  wire one_shot = sync_ctrl[`DSC_BIT_ONE_SHOT];
  wire sync_en  = sync_ctrl[`DSC_BIT_SYNC_EN];
  wire path_en  = stat_ctrl[`DSC_BIT_PATH_EN];

  // chip transfer strobe, self clearing
  wire xfer_hit = wr_en & hit_xfer & pstrb[0] & pwdata[`DSC_BIT_XFER];
  wire apply    = xfer_hit & upd_mode;

  // sysref qualification
  wire rise       = sysref_s & ~sysref_d;
  wire valid_edge = rise & path_en & sync_en & ~soft_rst;
  wire hw_clear   = valid_edge & one_shot;

  wire dsc_byte_t next_sync_ctrl =
    sync_wr  ? (pwdata[7:0] & `DSC_SYNC_WMASK) :
    hw_clear ? (sync_ctrl & ~(8'h01 << `DSC_BIT_SYNC_EN)) : sync_ctrl;
  wire next_pending = (|word_wr & upd_mode) | (pending & ~apply);

  wire dsc_byte_t stat_rd = stat_ctrl | {4'h0, sync_state, pending, 1'b0};

  // read mux
  wire dsc_word_t rd_data =
    hit_sync ? {24'h0, sync_ctrl} :
    hit_ddc0 ? {24'h0, ddc0_ctrl} :
    hit_stat ? {24'h0, stat_rd}   :
    hit_ftw  ? shadow[0] :
    hit_pow  ? shadow[1] :
    hit_maw  ? shadow[2] :
    hit_mbw  ? shadow[3] : 32'h0000_0000;

  assign frequency_tuning_word = active[0];
  assign phase_offset_word     = active[1];
  assign modulus_a_word        = active[2];
  assign modulus_b_word        = active[3];
  assign oscillator_soft_reset = soft_rst;
  assign mixer_type_select     = ddc0_ctrl[`DSC_BIT_MIXER];
  assign six_db_gain_select    = ddc0_ctrl[`DSC_BIT_GAIN];

  dsc_sync2 u_sysref_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (sysref_in),
    .sync_out (sysref_s)
  );

  // mode summary for status
  always_comb begin
    case ({sync_en, one_shot})
      2'b10:   next_sync_state = DSC_SY_CONT;
      2'b11:   next_sync_state = DSC_SY_ONCE;
      default: next_sync_state = DSC_SY_OFF;
    endcase
  end

  // apb answer: one wait state, pready for one cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_ctrl  <= `DSC_RST_SYNC;
      ddc0_ctrl  <= `DSC_RST_DDC0;
      stat_ctrl  <= `DSC_RST_STAT;
      pending    <= 1'b0;
      sync_state <= DSC_SY_OFF;
    end else begin
      sync_ctrl  <= next_sync_ctrl;
      ddc0_ctrl  <= ddc0_wr ? (pwdata[7:0] & `DSC_DDC0_WMASK) : ddc0_ctrl;
      stat_ctrl  <= stat_wr ? (pwdata[7:0] & `DSC_STAT_WMASK) : stat_ctrl;
      pending    <= next_pending;
      sync_state <= next_sync_state;
    end
  end

  // sysref edge and oscillator sync pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sysref_d <= 1'b0;
      nco_sync <= 1'b0;
    end else begin
      sysref_d <= sysref_s;
      nco_sync <= valid_edge;
    end
  end

  // tuning, phase and modulus words
  genvar gi;
  generate
    for (gi = 0; gi < `DSC_NUM_WORDS; gi++) begin : g_word
      assign word_wr[gi] = wr_en & hit_word[gi] & (|pstrb);
      assign merged[gi]  = (shadow[gi] & ~lane_mask) | (pwdata & lane_mask);
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          shadow[gi] <= `DSC_RST_WORD;
          active[gi] <= `DSC_RST_WORD;
        end else begin
          if (word_wr[gi]) begin
            shadow[gi] <= merged[gi];
          end
          if (word_wr[gi] && !upd_mode) begin
            active[gi] <= merged[gi];
          end else if (apply) begin
            active[gi] <= shadow[gi];
          end
        end
      end
    end
  endgenerate

  // checks
  sequence s_once_edge;
    valid_edge && one_shot && !sync_wr;
  endsequence

  sequence s_quiet_writes;
    !sync_wr [*2];
  endsequence

  sequence s_cont_edge;
    rise && path_en && sync_en && !one_shot && !soft_rst;
  endsequence

  property p_immediate;
    @(posedge sys_clk) disable iff (!rstn)
      (word_wr[0] && !upd_mode) |=> frequency_tuning_word == $past(merged[0]);
  endproperty

  immed_apply_a: assert property (p_immediate)
    else $error("word not applied at once in update mode 0");

  held_pending_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      (word_wr[1] && upd_mode) |=> $stable(phase_offset_word) && pending)
    else $error("word applied before transfer in update mode 1");

  xfer_apply_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      apply |=> modulus_a_word == $past(shadow[2]) && !pending)
    else $error("transfer did not apply pending words");

  reset_blocks_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      soft_rst |=> !nco_sync)
    else $error("oscillator sync during soft reset");

  cont_resync_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      s_cont_edge |=> nco_sync ##1 sync_en)
    else $error("continuous mode missed a sysref edge");

  once_only_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      s_once_edge ##1 s_quiet_writes |=> !nco_sync)
    else $error("later sysref edge used in one-shot mode");

  auto_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      s_once_edge |=> !sync_en && nco_sync)
    else $error("sync enable not cleared after one-shot capture");

  sync_off_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      (!sync_en || !path_en) |=> !nco_sync)
    else $error("alignment while synchronization disabled");

  mixer_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      ddc0_wr |=> mixer_type_select == $past(pwdata[`DSC_BIT_MIXER]))
    else $error("mixer select not taken from write");

  gain_sel_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      ddc0_wr |=> six_db_gain_select == $past(pwdata[`DSC_BIT_GAIN]))
    else $error("gain select not taken from write");

  edge_cause_a: assert property (
    @(posedge sys_clk) disable iff (!rstn)
      nco_sync |-> $past(sysref_s) && !$past(sysref_d))
    else $error("sync pulse without a registered rising sysref");

endmodule : dsc_sync_ctrl
`default_nettype wire

// [dsc_sysref_src.sv]
// sysref timing source model driving the sync pin
`timescale 1ns/100ps
`default_nettype none
module dsc_sysref_src (
  // train request
  input  wire logic       go,
  input  wire logic [3:0] n_pulses,
  // pin side
  output logic            sysref_in,
  output logic            busy
);
  initial begin
    sysref_in = 1'b0;
    busy      = 1'b0;
  end
  // fixed 50 ns period train, 12.5 sys_clk periods of 4 ns, not a whole multiple, low between edges
  always @(posedge go) begin
    busy = 1'b1;
    repeat (n_pulses) begin
      #12.7 sysref_in = 1'b1;
      #20.0 sysref_in = 1'b0;
      #17.3;
    end
    busy = 1'b0;
  end
endmodule : dsc_sysref_src
`default_nettype wire

// [tb_downconverter_sync_control.sv]
// self-checking bench of the downconverter sync control
`timescale 1ns/100ps
`default_nettype none
`include "dsc_map.svh"
module tb_downconverter_sync_control;
  import dsc_pkg::*;
  typedef struct {logic wr; dsc_word_t data; logic err;} dsc_note_t;
  logic       sys_clk  = 1'b0;
  logic       rstn     = 1'b0;
  dsc_addr_t  paddr    = '0;
  logic       psel     = 1'b0;
  logic       penable  = 1'b0;
  logic       pwrite   = 1'b0;
  dsc_word_t  pwdata   = '0;
  logic       go       = 1'b0;
  logic [3:0] n_pulses = 4'h0;
  logic [3:0] pstrb    = 4'hf;
  dsc_word_t  prdata;
  logic       pready, pslverr, sysref_in, nco_sync, busy;
  logic       mixer_type_select, six_db_gain_select, oscillator_soft_reset;
  dsc_word_t  words [4];
  dsc_note_t  notes [$];
  dsc_note_t  nt;
  dsc_word_t  rnd, old;
  int         n_errors = 0, samples_checked = 0, n_sync = 0, seed = 22;

  dsc_sysref_src src (.go(go), .n_pulses(n_pulses), .sysref_in(sysref_in), .busy(busy));
  dsc_sync_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysref_in(sysref_in),
    .frequency_tuning_word(words[0]), .phase_offset_word(words[1]),
    .modulus_a_word(words[2]), .modulus_b_word(words[3]),
    .oscillator_soft_reset(oscillator_soft_reset), .nco_sync(nco_sync),
    .mixer_type_select(mixer_type_select), .six_db_gain_select(six_db_gain_select));

  always #2 sys_clk = ~sys_clk;

  task automatic fail(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic chk(input dsc_word_t got, input dsc_word_t exp, input string msg);
    samples_checked++;
    if (got !== exp) fail(msg);
  endtask : chk

  // answer monitor: oldest note against each pready
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        fail("answer without request");
      end else begin
        nt = notes.pop_front();
        samples_checked++;
        if (pslverr !== nt.err || (!nt.wr && prdata !== nt.data)) fail("apb answer mismatch");
      end
    end
    if (nco_sync === 1'b1) n_sync++;
  end

  task automatic apb(input logic wr, input dsc_idx_t idx, input dsc_word_t wd,
                     input dsc_word_t exp, input logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    notes.push_back('{wr, exp, err});
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fail("no pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input dsc_idx_t idx, input dsc_word_t d);
    apb(1'b1, idx, d, 32'h0, 1'b0);
  endtask : wr_reg

  task automatic rd_reg(input dsc_idx_t idx, input dsc_word_t e);
    apb(1'b0, idx, 32'h0, e, 1'b0);
  endtask : rd_reg

  task automatic train(input logic [3:0] n, input int exp, input string msg);
    int k;
    k = 0;
    n_sync = 0;
    n_pulses <= n;
    go       <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (busy && k < 100);
    if (k >= 100) fail("sysref train hung");
    repeat (8) @(posedge sys_clk);
    chk(dsc_word_t'(n_sync), dsc_word_t'(exp), msg);
  endtask : train

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #50000;
    fail("watchdog expired");
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_reg(`DSC_IDX_SYNC, 32'h0);
    rd_reg(`DSC_IDX_DDC0, 32'h0);
    rd_reg(`DSC_IDX_STAT, 32'h0);
    for (int i = 0; i < 4; i++) chk(words[i], 32'h0, "word reset value");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      wr_reg(dsc_idx_t'(`DSC_IDX_FTW + i), rnd);
      repeat (2) @(posedge sys_clk);
      chk(words[i], rnd, "word not applied at once");
      rd_reg(dsc_idx_t'(`DSC_IDX_FTW + i), rnd);
    end
    wr_reg(`DSC_IDX_FTW, 32'h1234_5678);
    pstrb <= 4'h3;
    rnd = $random(seed);
    wr_reg(`DSC_IDX_FTW, rnd);
    pstrb <= 4'h0;
    wr_reg(`DSC_IDX_FTW, 32'hffff_ffff);
    pstrb <= 4'hf;
    repeat (2) @(posedge sys_clk);
    chk(words[0], {16'h1234, rnd[15:0]}, "byte lanes not honoured");
    $display("test immediate update done");
    wr_reg(`DSC_IDX_SYNC, 32'hff);
    rd_reg(`DSC_IDX_SYNC, 32'h93);
    wr_reg(`DSC_IDX_SYNC, 32'h80);
    old = words[1];
    rnd = $random(seed);
    wr_reg(`DSC_IDX_POW, rnd);
    repeat (2) @(posedge sys_clk);
    chk(words[1], old, "word applied before transfer");
    rd_reg(`DSC_IDX_STAT, 32'h2);
    wr_reg(`DSC_IDX_XFER, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(words[1], rnd, "word not transferred");
    rd_reg(`DSC_IDX_XFER, 32'h0);
    $display("test held update done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(`DSC_IDX_DDC0, {24'hffffff, i[1:0], 6'h3f});
      rd_reg(`DSC_IDX_DDC0, {24'h0, i[1:0], 6'h0});
      chk({31'h0, mixer_type_select}, {31'h0, i[1]}, "mixer type");
      chk({31'h0, six_db_gain_select}, {31'h0, i[0]}, "gain select");
    end
    $display("test mixer and gain done");
    wr_reg(`DSC_IDX_STAT, 32'h1);
    wr_reg(`DSC_IDX_SYNC, 32'h11);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, oscillator_soft_reset}, 32'h1, "soft reset level");
    train(4'h2, 0, "sync while held in reset");
    wr_reg(`DSC_IDX_SYNC, 32'h01);
    train(4'h3, 3, "continuous sync count");
    rd_reg(`DSC_IDX_SYNC, 32'h01);
    chk({31'h0, oscillator_soft_reset}, 32'h0, "soft reset release");
    rd_reg(`DSC_IDX_STAT, 32'h05);
    wr_reg(`DSC_IDX_SYNC, 32'h03);
    rd_reg(`DSC_IDX_STAT, 32'h09);
    train(4'h3, 1, "one-shot sync count");
    rd_reg(`DSC_IDX_SYNC, 32'h02);
    rd_reg(`DSC_IDX_STAT, 32'h01);
    wr_reg(`DSC_IDX_SYNC, 32'h00);
    train(4'h2, 0, "sync while disabled");
    wr_reg(`DSC_IDX_STAT, 32'h0);
    wr_reg(`DSC_IDX_SYNC, 32'h01);
    train(4'h2, 0, "sync with path off");
    $display("test sysref alignment done");
    apb(1'b0, 12'h330, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h330, 32'h5a, 32'h0, 1'b1);
    rd_reg(`DSC_IDX_SYNC, 32'h01);
    $display("test unmapped access done");
    repeat (4) @(posedge sys_clk);
    tally_and_finish;
  end
endmodule : tb_downconverter_sync_control
`default_nettype wire
